// >>> design/tcc_timer16_cc.sv
module tcc_timer16_cc #(
	parameter int CNT_W = 16,
	parameter bit HAS_ACOMP = 1'b1
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire tcc_pkg::tcc_bus_t CPU_REQ,
	output logic [7:0] RDATA,
	input wire logic [CNT_W-1:0] COUNTER_VALUE,
	input wire logic TIMER_TICK,
	input wire logic CNT_WRITE,
	input wire logic OVF_EVENT,
	input wire logic TOP_REACHED,
	input wire logic CAPTURE_IS_TOP,
	input wire logic CAPTURE_PIN,
	input wire logic ACOMP_OUT,
	input wire logic GLOBAL_IE,
	input wire logic [7:0] IRQ_ACK,
	output logic [7:0] IRQ_REQ,
	output logic [2:0] MATCH_OUT,
	output logic [CNT_W-1:0] CAPTURE_TOP
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [CNT_W-1:0] cmp_q [3];
	logic [CNT_W-1:0] cap_q;
	logic [7:0] temp_q;
	logic [7:0] en_q;
	logic [7:0] flags_q;
	logic [7:0] ctrl_q;
	logic block_q;
	logic [7:0] rdata_q;
	logic [7:0] irq_q;
	logic [2:0] match_q;
	logic [2:0] hit;
	logic cap_ev;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire logic [3:0] addr = CPU_REQ.addr;
	wire logic [7:0] wdata = CPU_REQ.wdata;
	wire logic wr = CPU_REQ.wr;
	wire logic rd = CPU_REQ.rd && !CPU_REQ.wr;
	wire logic wr_hi = wr && addr[0] && (addr <= tcc_pkg::OFS_CAP_H);
	wire logic wr_lo_a = wr && (addr == tcc_pkg::OFS_CMPA_L);
	wire logic wr_lo_b = wr && (addr == tcc_pkg::OFS_CMPB_L);
	wire logic wr_lo_c = wr && (addr == tcc_pkg::OFS_CMPC_L);
	wire logic wr_lo_cap = wr && (addr == tcc_pkg::OFS_CAP_L);
	wire logic wr_en = wr && (addr == tcc_pkg::OFS_IRQ_EN);
	wire logic wr_flags = wr && (addr == tcc_pkg::OFS_IRQ_FLAGS);
	wire logic wr_ctrl = wr && (addr == tcc_pkg::OFS_CTRL);
	wire logic wr_force = wr && (addr == tcc_pkg::OFS_FORCE);
	wire logic rd_lo_cap = rd && (addr == tcc_pkg::OFS_CAP_L);
	wire logic [2:0] wr_lo_cmp = {wr_lo_c, wr_lo_b, wr_lo_a};

	// commit value for any high-first word write
	wire logic [15:0] word_wr = {temp_q, wdata};

	// ----------------------------------------
	// compare channels
	// ----------------------------------------
	// a counter write blocks matches up to and including the next tick
	wire logic block_d = CNT_WRITE || (block_q && !TIMER_TICK);

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_cmp
			tcc_cmp_chan #(
				.W(CNT_W)
			) u_cmp (
				.clk(REF_CLK),
				.rst_n(RST_N),
				.tick(TIMER_TICK),
				.block(block_q),
				.counter(COUNTER_VALUE),
				.compare(cmp_q[g]),
				.hit_q(hit[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// capture source
	// ----------------------------------------
	wire logic use_acomp = HAS_ACOMP && ctrl_q[tcc_pkg::CTRL_USE_ACOMP];

	tcc_capture u_cap (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.pin(CAPTURE_PIN),
		.acomp(ACOMP_OUT),
		.use_acomp(use_acomp),
		.edge_rise(ctrl_q[tcc_pkg::CTRL_EDGE_RISE]),
		.disconnect(CAPTURE_IS_TOP),
		.event_q(cap_ev)
	);

	// ----------------------------------------
	// flag set / clear
	// ----------------------------------------
	logic [7:0] set_v;
	always_comb begin
		set_v = 8'h00;
		set_v[tcc_pkg::BIT_CAP] = cap_ev || (CAPTURE_IS_TOP && TOP_REACHED);
		set_v[tcc_pkg::BIT_CMPC] = hit[2];
		set_v[tcc_pkg::BIT_CMPB] = hit[1];
		set_v[tcc_pkg::BIT_CMPA] = hit[0];
		set_v[tcc_pkg::BIT_OVF] = OVF_EVENT;
	end

	// write-one-to-clear or vector acknowledge; a same-cycle set wins
	wire logic [7:0] clr_v = IRQ_ACK | (wr_flags ? wdata : 8'h00);
	wire logic [7:0] flags_d = (set_v | (flags_q & ~clr_v)) & tcc_pkg::FLAG_MASK;
	wire logic [7:0] irq_d = GLOBAL_IE ? (en_q & flags_q) : 8'h00;
	// forced strobes reach the waveform side only, never the flags
	wire logic [2:0] force_v = wr_force ? wdata[tcc_pkg::FORCE_A +: 3] : 3'b000;

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	logic [7:0] rdata_d;
	always_comb begin
		case (addr)
			tcc_pkg::OFS_CMPA_L: rdata_d = cmp_q[0][7:0];
			tcc_pkg::OFS_CMPA_H: rdata_d = cmp_q[0][15:8];
			tcc_pkg::OFS_CMPB_L: rdata_d = cmp_q[1][7:0];
			tcc_pkg::OFS_CMPB_H: rdata_d = cmp_q[1][15:8];
			tcc_pkg::OFS_CMPC_L: rdata_d = cmp_q[2][7:0];
			tcc_pkg::OFS_CMPC_H: rdata_d = cmp_q[2][15:8];
			tcc_pkg::OFS_CAP_L: rdata_d = cap_q[7:0];
			tcc_pkg::OFS_CAP_H: rdata_d = temp_q;
			tcc_pkg::OFS_IRQ_EN: rdata_d = en_q;
			tcc_pkg::OFS_IRQ_FLAGS: rdata_d = flags_q;
			tcc_pkg::OFS_CTRL: rdata_d = ctrl_q;
			default: rdata_d = 8'h00;
		endcase
	end

	// ----------------------------------------
	// temporary high byte and data registers
	// ----------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			temp_q <= tcc_pkg::RST_BYTE;
		end else if (wr_hi) begin
			temp_q <= wdata;
		end else if (rd_lo_cap) begin
			temp_q <= cap_q[15:8];
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cmp_q[0] <= tcc_pkg::RST_WORD;
			cmp_q[1] <= tcc_pkg::RST_WORD;
			cmp_q[2] <= tcc_pkg::RST_WORD;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (wr_lo_cmp[i]) begin
					cmp_q[i] <= word_wr;
				end
			end
		end
	end

	// a hardware capture outranks a software write in the same cycle
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cap_q <= tcc_pkg::RST_WORD;
		end else if (cap_ev) begin
			cap_q <= COUNTER_VALUE;
		end else if (wr_lo_cap) begin
			cap_q <= word_wr;
		end
	end

	// ----------------------------------------
	// control, enables, flags
	// ----------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			en_q <= tcc_pkg::RST_BYTE;
			ctrl_q <= tcc_pkg::RST_BYTE;
		end else begin
			if (wr_en) begin
				en_q <= wdata & tcc_pkg::FLAG_MASK;
			end
			if (wr_ctrl) begin
				ctrl_q <= wdata & tcc_pkg::CTRL_MASK;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			flags_q <= tcc_pkg::RST_BYTE;
			block_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			block_q <= block_d;
		end
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_q <= tcc_pkg::RST_BYTE;
			irq_q <= tcc_pkg::RST_BYTE;
			match_q <= 3'b000;
		end else begin
			if (rd) begin
				rdata_q <= rdata_d;
			end
			irq_q <= irq_d;
			match_q <= hit | force_v;
		end
	end

	assign RDATA = rdata_q;
	assign IRQ_REQ = irq_q;
	assign MATCH_OUT = match_q;
	assign CAPTURE_TOP = cap_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);

	AST_CMP_FLAG_NEXT: assert property (
		(TIMER_TICK && !block_q && COUNTER_VALUE == cmp_q[0])
		|-> ##2 flags_q[tcc_pkg::BIT_CMPA])
		else $error("compare A flag not set after match");

	AST_WRITE_BLOCKS: assert property (
		(CNT_WRITE ##1 (TIMER_TICK && !CNT_WRITE)) |=> (hit == 3'b000))
		else $error("match not blocked after counter write");

	AST_FORCE_NO_FLAG: assert property (
		(wr_force && !TIMER_TICK && !hit[0] && !flags_q[tcc_pkg::BIT_CMPA])
		|=> !flags_q[tcc_pkg::BIT_CMPA])
		else $error("force strobe set compare flag");

	AST_CAP_COPY: assert property (
		cap_ev |=> (cap_q == $past(COUNTER_VALUE)) && flags_q[tcc_pkg::BIT_CAP])
		else $error("capture did not copy counter or set flag");

	AST_CAP_DISCONNECT: assert property (
		CAPTURE_IS_TOP |=> !cap_ev)
		else $error("capture event while capture is top");

	AST_CAP_TOP_FLAG: assert property (
		(CAPTURE_IS_TOP && TOP_REACHED) |=> flags_q[tcc_pkg::BIT_CAP])
		else $error("capture flag not set at top");

	AST_OVF_CLEAR: assert property (
		(wr_flags && wdata[tcc_pkg::BIT_OVF] && !OVF_EVENT)
		|=> !flags_q[tcc_pkg::BIT_OVF])
		else $error("overflow flag not cleared by write one");

	AST_OVF_SET: assert property (
		OVF_EVENT |=> flags_q[tcc_pkg::BIT_OVF])
		else $error("overflow flag lost");

	AST_IRQ_B: assert property (
		(GLOBAL_IE && en_q[tcc_pkg::BIT_CMPB] && flags_q[tcc_pkg::BIT_CMPB])[*2]
		|-> IRQ_REQ[tcc_pkg::BIT_CMPB])
		else $error("channel B request missing");

	AST_IRQ_GATED: assert property (
		!GLOBAL_IE |=> !IRQ_REQ[tcc_pkg::BIT_CAP])
		else $error("capture request without global enable");

	AST_WORD_WRITE: assert property (
		(wr && addr == tcc_pkg::OFS_CMPB_H ##1 wr_lo_b)
		|=> cmp_q[1] == {$past(CPU_REQ.wdata, 2), $past(CPU_REQ.wdata)})
		else $error("compare B word write torn");

	AST_CAP_READ: assert property (
		(rd_lo_cap ##1 (rd && addr == tcc_pkg::OFS_CAP_H))
		|=> RDATA == $past(cap_q[15:8], 2))
		else $error("capture high byte not coherent");

	AST_IRQ_A: assert property (
		(GLOBAL_IE && en_q[tcc_pkg::BIT_CMPA] && flags_q[tcc_pkg::BIT_CMPA])[*2]
		|-> IRQ_REQ[tcc_pkg::BIT_CMPA])
		else $error("channel A request missing");

	AST_IRQ_C: assert property (
		(GLOBAL_IE && en_q[tcc_pkg::BIT_CMPC] && flags_q[tcc_pkg::BIT_CMPC])[*2]
		|-> IRQ_REQ[tcc_pkg::BIT_CMPC])
		else $error("channel C request missing");

	AST_IRQ_OVF: assert property (
		(GLOBAL_IE && en_q[tcc_pkg::BIT_OVF] && flags_q[tcc_pkg::BIT_OVF])[*2]
		|-> IRQ_REQ[tcc_pkg::BIT_OVF])
		else $error("overflow request missing");

	AST_IRQ_CAP: assert property (
		(GLOBAL_IE && en_q[tcc_pkg::BIT_CAP] && flags_q[tcc_pkg::BIT_CAP])[*2]
		|-> IRQ_REQ[tcc_pkg::BIT_CAP])
		else $error("capture request missing");

	AST_MATCH_OUT: assert property (
		hit[0] |=> MATCH_OUT[0])
		else $error("channel A match not driven out");

	AST_ACK_CLEAR_C: assert property (
		(IRQ_ACK[tcc_pkg::BIT_CMPC] && !hit[2]) |=> !flags_q[tcc_pkg::BIT_CMPC])
		else $error("channel C flag not cleared by vector");

	AST_CAP_RISE: assert property (
		(ctrl_q[tcc_pkg::CTRL_EDGE_RISE] && !use_acomp && !$past(use_acomp)
		&& !CAPTURE_IS_TOP && $rose(CAPTURE_PIN)) |=> cap_ev)
		else $error("rising pin edge not captured");

	AST_CAP_FALL: assert property (
		(!ctrl_q[tcc_pkg::CTRL_EDGE_RISE] && !use_acomp && !$past(use_acomp)
		&& !CAPTURE_IS_TOP && $fell(CAPTURE_PIN)) |=> cap_ev)
		else $error("falling pin edge not captured");

endmodule // tcc_timer16_cc

// >>> design/tcc_pkg.sv
package tcc_pkg;

	// ----------------------------------------
	// register offsets on the core bus
	// ----------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFS_CMPA_L = 4'h0;
	localparam logic [3:0] OFS_CMPA_H = 4'h1;
	localparam logic [3:0] OFS_CMPB_L = 4'h2;
	localparam logic [3:0] OFS_CMPB_H = 4'h3;
	localparam logic [3:0] OFS_CMPC_L = 4'h4;
	localparam logic [3:0] OFS_CMPC_H = 4'h5;
	localparam logic [3:0] OFS_CAP_L = 4'h6;
	localparam logic [3:0] OFS_CAP_H = 4'h7;
	localparam logic [3:0] OFS_IRQ_EN = 4'h8;
	localparam logic [3:0] OFS_IRQ_FLAGS = 4'h9;
	localparam logic [3:0] OFS_CTRL = 4'hA;
	localparam logic [3:0] OFS_FORCE = 4'hB;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int BIT_OVF = 0;
	localparam int BIT_CMPA = 1;
	localparam int BIT_CMPB = 2;
	localparam int BIT_CMPC = 3;
	localparam int BIT_CAP = 5;
	localparam logic [7:0] FLAG_MASK = 8'h2F;
	localparam int CTRL_EDGE_RISE = 0;
	localparam int CTRL_USE_ACOMP = 1;
	localparam logic [7:0] CTRL_MASK = 8'h03;
	localparam int FORCE_A = 0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;

	typedef struct packed {
		logic [3:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} tcc_bus_t;

endpackage

// >>> design/tcc_cmp_chan.sv
module tcc_cmp_chan #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic block,
	input wire logic [W-1:0] counter,
	input wire logic [W-1:0] compare,
	output logic hit_q
);

	// ----------------------------------------
	// comparator, sampled on the timer tick
	// ----------------------------------------
	wire logic equal = (counter == compare);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hit_q <= 1'b0;
		end else begin
			hit_q <= tick && !block && equal;
		end
	end

endmodule // tcc_cmp_chan

// >>> design/tcc_capture.sv
module tcc_capture (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin,
	input wire logic acomp,
	input wire logic use_acomp,
	input wire logic edge_rise,
	input wire logic disconnect,
	output logic event_q
);

	// ----------------------------------------
	// edge detector on the selected source
	// ----------------------------------------
	// changing source may fake one edge; software should clear the flag after
	logic prev_q;
	wire logic src = use_acomp ? acomp : pin;
	wire logic rise = src && !prev_q;
	wire logic fall = !src && prev_q;
	wire logic hit = edge_rise ? rise : fall;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= 1'b0;
			event_q <= 1'b0;
		end else begin
			prev_q <= src;
			event_q <= !disconnect && hit;
		end
	end

endmodule // tcc_capture

// >>> testbench/tcc_core_model.sv
module tcc_core_model (
	input wire logic clk,
	input wire logic [7:0] rdata,
	output tcc_pkg::tcc_bus_t req
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		req = '0;
	end

	// ----------------------------------------
	// byte cycles, idle cycle after each
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(negedge clk);
		req = '0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(negedge clk);
		req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(negedge clk);
		req = '0;
		d = rdata;
	endtask

	// high byte first: it only fills the shared latch; both bytes back to back
	task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
		@(negedge clk);
		req = '{addr: lo + 4'h1, wr: 1'b1, rd: 1'b0, wdata: v[15:8]};
		@(negedge clk);
		req = '{addr: lo, wr: 1'b1, rd: 1'b0, wdata: v[7:0]};
		@(negedge clk);
		req = '0;
	endtask

	// low byte first, which loads the latch for the capture register only; high byte follows at once
	task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
		@(negedge clk);
		req = '{addr: lo, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(negedge clk);
		v[7:0] = rdata;
		req = '{addr: lo + 4'h1, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(negedge clk);
		req = '0;
		v[15:8] = rdata;
	endtask
endmodule // tcc_core_model

// >>> testbench/test_timer16_compare_capture_irq.sv
module test_timer16_compare_capture_irq;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, rst_n, tick, cnt_wr, ovf, top_hit, cap_top, cap_pin, acomp, gie;
	logic [15:0] cnt, d16, ctop;
	logic [7:0] ack, rdata, irq, d8;
	logic [2:0] match;
	tcc_pkg::tcc_bus_t req;
	int n_mismatch, cmp_count, cycles, b;
	logic [15:0] cv [3] = '{16'h0000, 16'h1234, 16'h5678};

	tcc_core_model tcc_core_model_inst (.clk(ref_clk), .rdata(rdata), .req(req));
	tcc_timer16_cc tcc_timer16_cc_inst (.REF_CLK(ref_clk), .RST_N(rst_n), .CPU_REQ(req),
		.RDATA(rdata), .COUNTER_VALUE(cnt), .TIMER_TICK(tick), .CNT_WRITE(cnt_wr),
		.OVF_EVENT(ovf), .TOP_REACHED(top_hit), .CAPTURE_IS_TOP(cap_top),
		.CAPTURE_PIN(cap_pin), .ACOMP_OUT(acomp), .GLOBAL_IE(gie), .IRQ_ACK(ack),
		.IRQ_REQ(irq), .MATCH_OUT(match), .CAPTURE_TOP(ctop));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// hang guard, tests need well under a thousand cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic rreg(input string what, input logic [3:0] a, input logic [7:0] exp);
		tcc_core_model_inst.rd(a, d8);
		chk(what, {8'h00, exp}, {8'h00, d8});
	endtask

	task automatic ack_pulse(input logic [7:0] m);
		step(1);
		ack = m;
		step(1);
		ack = 8'h00;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rst_n, tick, cnt_wr, ovf, top_hit, cap_top, cap_pin, acomp, gie} = '0;
		cnt = 16'h0000;
		ack = 8'h00;
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		rreg("enable reset", tcc_pkg::OFS_IRQ_EN, 8'h00);
		rreg("flags reset", tcc_pkg::OFS_IRQ_FLAGS, 8'h00);
		rreg("unmapped", 4'hC, 8'h00);
		tcc_core_model_inst.wr(tcc_pkg::OFS_IRQ_EN, 8'hFF);
		rreg("enable reserved", tcc_pkg::OFS_IRQ_EN, tcc_pkg::FLAG_MASK);
		tcc_core_model_inst.wr16(tcc_pkg::OFS_CMPB_L, 16'h1234);
		tcc_core_model_inst.rd16(tcc_pkg::OFS_CMPB_L, d16);
		chk("compare b", 16'h1234, d16);
		// latch shared: channel A high byte lands in channel C
		tcc_core_model_inst.wr(tcc_pkg::OFS_CMPA_H, 8'h56);
		tcc_core_model_inst.wr(tcc_pkg::OFS_CMPC_L, 8'h78);
		tcc_core_model_inst.rd16(tcc_pkg::OFS_CMPC_L, d16);
		chk("compare c", 16'h5678, d16);
		gie = 1'b1;
		for (b = 1; b <= 3; b++) begin
			cnt = cv[b - 1];
			step(1);
			tick = 1'b1;
			step(1);
			tick = 1'b0;
			step(1);
			chk("match out", 16'(3'b001 << (b - 1)), 16'(match));
			step(1);
			chk("compare irq", 16'(8'h01 << b), 16'(irq));
			tcc_core_model_inst.wr(tcc_pkg::OFS_IRQ_FLAGS, 8'(8'h01 << b));
			rreg("flag write one", tcc_pkg::OFS_IRQ_FLAGS, 8'h00);
		end
		// counter write at k blocks the tick at k+1, later ticks match
		step(1);
		cnt_wr = 1'b1;
		step(1);
		cnt_wr = 1'b0;
		tick = 1'b1;
		step(1);
		tick = 1'b0;
		step(3);
		rreg("blocked match", tcc_pkg::OFS_IRQ_FLAGS, 8'h00);
		tick = 1'b1;
		step(1);
		tick = 1'b0;
		step(3);
		rreg("match after block", tcc_pkg::OFS_IRQ_FLAGS, 8'h08);
		ack_pulse(8'h08);
		rreg("flag vector clear", tcc_pkg::OFS_IRQ_FLAGS, 8'h00);
		tcc_core_model_inst.wr(tcc_pkg::OFS_FORCE, 8'h07);
		chk("force match", 16'h0007, 16'(match));
		step(3);
		rreg("force no flag", tcc_pkg::OFS_IRQ_FLAGS, 8'h00);
		rreg("force reads zero", tcc_pkg::OFS_FORCE, 8'h00);
		step(1);
		ovf = 1'b1;
		step(1);
		ovf = 1'b0;
		step(3);
		chk("overflow irq", 16'h0001, 16'(irq));
		ack_pulse(8'h01);
		rreg("overflow clear", tcc_pkg::OFS_IRQ_FLAGS, 8'h00);
		ovf = 1'b1;
		step(1);
		ovf = 1'b0;
		rreg("overflow set", tcc_pkg::OFS_IRQ_FLAGS, 8'h01);
		tcc_core_model_inst.wr(tcc_pkg::OFS_IRQ_FLAGS, 8'h01);
		rreg("overflow write one", tcc_pkg::OFS_IRQ_FLAGS, 8'h00);
		// falling edge then rising edge; the opposite edge must stay quiet
		for (b = 0; b < 2; b++) begin
			cap_pin = ~b[0];
			tcc_core_model_inst.wr(tcc_pkg::OFS_CTRL, 8'(b));
			tcc_core_model_inst.wr(tcc_pkg::OFS_IRQ_FLAGS, 8'h20);
			gie = 1'b0;
			cnt = 16'hAB00 | 16'(b);
			step(1);
			cap_pin = b[0];
			step(4);
			chk("gated irq", 16'h0000, 16'(irq));
			gie = 1'b1;
			step(2);
			chk("capture irq", 16'h0020, 16'(irq));
			cnt = 16'h0000;
			tcc_core_model_inst.rd16(tcc_pkg::OFS_CAP_L, d16);
			chk("capture value", 16'hAB00 | 16'(b), d16);
			ack_pulse(8'h20);
			cap_pin = ~b[0];
			step(4);
			rreg("wrong edge", tcc_pkg::OFS_IRQ_FLAGS, 8'h00);
		end
		cap_top = 1'b1;
		cnt = 16'h0F0F;
		// selected rising edge while disconnected
		cap_pin = 1'b1;
		step(4);
		rreg("pin disconnected", tcc_pkg::OFS_IRQ_FLAGS, 8'h00);
		chk("capture top", 16'hAB01, ctop);
		top_hit = 1'b1;
		step(1);
		top_hit = 1'b0;
		step(3);
		rreg("top flag", tcc_pkg::OFS_IRQ_FLAGS, 8'h20);
		// comparator as source on a rising edge; the pin stays steady
		cap_top = 1'b0;
		tcc_core_model_inst.wr(tcc_pkg::OFS_CTRL, 8'h03);
		tcc_core_model_inst.wr(tcc_pkg::OFS_IRQ_FLAGS, 8'h20);
		cnt = 16'hC0DE;
		acomp = 1'b1;
		step(3);
		rreg("comparator flag", tcc_pkg::OFS_IRQ_FLAGS, 8'h20);
		tcc_core_model_inst.rd16(tcc_pkg::OFS_CAP_L, d16);
		chk("comparator capture", 16'hC0DE, d16);
		end_of_test();
	end
endmodule // test_timer16_compare_capture_irq
